//--- inc/tfg_defines.svh
// Function
// - test runs while the generate enable is on and stops when it goes off.
// - every generated frame holds exactly the configured frame length in bytes, or one byte when the length is 0.
// - read-only sync flag sets once the checker locks onto received test frames.
// - received test frames are counted during the test and readable.
// - received test frames found in error are totalled, read-only.
// - seconds holding at least one detected or inserted error are counted, read-only.
// - elapsed test seconds advance once per second while the test runs.
// - deliberately injected errors are counted, read-only.
// - each insert-error command corrupts the outgoing test stream once; one given while another is still pending merges with it.
`ifndef TFG_DEFINES_SVH
`define TFG_DEFINES_SVH

// register byte addresses
`define TFG_ADDR_CTRL      12'h000
`define TFG_ADDR_LEN       12'h004
`define TFG_ADDR_STATUS    12'h008
`define TFG_ADDR_FRX       12'h00C
`define TFG_ADDR_EFC       12'h010
`define TFG_ADDR_ESC       12'h014
`define TFG_ADDR_TEST_ELAPSED_SECONDS      12'h018
`define TFG_ADDR_IEC       12'h01C

// field positions
`define TFG_CTRL_EN_BIT    0
`define TFG_CTRL_INS_BIT   1
`define TFG_STAT_SYNC_BIT  0
`define TFG_STAT_RUN_BIT   1
`define TFG_STAT_BUSY_BIT  2

// reset values
`define TFG_LEN_RST        16'h0020

// checker lock thresholds
`define TFG_SYNC_SET       2'h2
`define TFG_SYNC_LOSS      2'h3

// timing
`define TFG_CLK_PERIOD_NS  10
`define TFG_ONE_SEC_NS     1000000000
`define TFG_SEC_CYCLES     (`TFG_ONE_SEC_NS / `TFG_CLK_PERIOD_NS)

`endif

//--- inc/tfg_pkg.sv
package tfg_pkg;

	// generator states
	typedef enum logic {
		GEN_IDLE,
		GEN_SEND
	} tfg_gen_st_t;

	typedef logic [31:0] tfg_cnt_t;

	// conditional counter step
	function automatic tfg_cnt_t tfg_cnt_inc(input tfg_cnt_t c, input logic en);
		tfg_cnt_inc = en ? c + 32'h0000_0001 : c;
	endfunction

endpackage

//--- src/tfg_sec_tick.sv
`timescale 1ns/10ps
module tfg_sec_tick #(
	parameter int unsigned P_CYCLES = 100
) (
	// clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_nrst,
	input  wire logic i_ce,
	// control
	input  wire logic i_restart,
	// tick out
	output logic      o_tick
);

	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic        wrap;

	// one pulse every P_CYCLES enabled cycles
	assign wrap   = (cnt_q == 32'(P_CYCLES - 1));
	assign cnt_d  = (i_restart | wrap) ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
	assign o_tick = wrap & ~i_restart & i_ce;

	// divider count
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_q <= 32'h0000_0000;
		end else if (i_ce) begin
			cnt_q <= cnt_d;
		end
	end

endmodule

//--- src/tfg_buf2.sv
`timescale 1ns/10ps
module tfg_buf2 #(
	parameter int unsigned P_WIDTH = 9
) (
	// clock and reset
	input  wire logic               i_ref_clk,
	input  wire logic               i_nrst,
	input  wire logic               i_ce,
	// fill side
	input  wire logic               i_valid,
	output logic                    o_ready,
	input  wire logic [P_WIDTH-1:0] i_data,
	// drain side
	output logic                    o_valid,
	input  wire logic               i_ready,
	output logic [P_WIDTH-1:0]      o_data
);

	logic [P_WIDTH-1:0] e0_q;
	logic [P_WIDTH-1:0] e1_q;
	logic [1:0]         cnt_q;
	logic               push;
	logic               pop;

	// two entries, head always in e0
	assign o_ready = (cnt_q != 2'h2);
	assign o_valid = (cnt_q != 2'h0);
	assign o_data  = e0_q;
	assign push    = i_valid & o_ready & i_ce;
	assign pop     = o_valid & i_ready & i_ce;

	// storage and fill level
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			e0_q  <= '0;
			e1_q  <= '0;
			cnt_q <= 2'h0;
		end else begin
			if (pop) begin
				e0_q <= (push && cnt_q == 2'h1) ? i_data : e1_q;
			end else if (push && cnt_q == 2'h0) begin
				e0_q <= i_data;
			end
			if (push && ((cnt_q == 2'h1 && !pop) || (cnt_q == 2'h2))) begin
				e1_q <= i_data;
			end
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end

endmodule

//--- src/tfg_top.sv
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/10ps
`include "tfg_defines.svh"
module tfg_top
	import tfg_pkg::*;
#(
	parameter int unsigned P_SEC_CYCLES = `TFG_SEC_CYCLES
) (
	// clock, reset, enable
	input  wire logic        i_ref_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_ce,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [3:0]  i_pstrb,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// transmit byte stream toward line
	output logic             o_tx_valid,
	input  wire logic        i_tx_ready,
	output logic [7:0]       o_tx_data,
	output logic             o_tx_last,
	// receive byte stream from line
	input  wire logic        i_rx_valid,
	input  wire logic [7:0]  i_rx_data,
	input  wire logic        i_rx_last,
	input  wire logic        i_rx_err
);

	////////////////////////////////////////////////////////////////////////
	// register state

	logic        test_generate_enable_q;
	logic [15:0] frame_len_q;
	logic        ins_pend_q;
	logic        ins_pend_d;
	logic [31:0] prdata_q;
	logic        acc_q;

	tfg_cnt_t    frames_received_count_q;
	tfg_cnt_t    errored_frame_count_q;
	tfg_cnt_t    errored_second_count_q;
	tfg_cnt_t    test_elapsed_seconds_q;
	tfg_cnt_t    inserted_error_count_q;

	logic        sync_q;
	logic [1:0]  good_run_q;
	logic [1:0]  bad_run_q;
	logic        sec_err_q;
	logic        sec_err_d;

	////////////////////////////////////////////////////////////////////////
	// apb decode

	logic        wr_fire;
	logic        hit_ctrl;
	logic        hit_len;
	logic        hit_status;
	logic        hit_frx;
	logic        hit_efc;
	logic        hit_esc;
	logic        hit_test_elapsed_seconds;
	logic        hit_iec;
	logic        addr_hit;
	logic [31:0] rd_mux;
	logic        ctrl_wr;
	logic        en_wr_val;
	logic        ins_cmd;
	logic        start;
	logic        gen_busy;

	// address match per register
	assign hit_ctrl   = (i_paddr == `TFG_ADDR_CTRL);
	assign hit_len    = (i_paddr == `TFG_ADDR_LEN);
	assign hit_status = (i_paddr == `TFG_ADDR_STATUS);
	assign hit_frx    = (i_paddr == `TFG_ADDR_FRX);
	assign hit_efc    = (i_paddr == `TFG_ADDR_EFC);
	assign hit_esc    = (i_paddr == `TFG_ADDR_ESC);
	assign hit_test_elapsed_seconds   = (i_paddr == `TFG_ADDR_TEST_ELAPSED_SECONDS);
	assign hit_iec    = (i_paddr == `TFG_ADDR_IEC);
	assign addr_hit   = hit_ctrl | hit_len | hit_status | hit_frx | hit_efc | hit_esc | hit_test_elapsed_seconds | hit_iec;

	// access completes one cycle after read data was captured
	assign o_pready  = i_ce & acc_q;
	assign o_pslverr = o_pready & i_psel & i_penable & ~addr_hit;
	assign o_prdata  = prdata_q;
	assign wr_fire   = o_pready & i_psel & i_penable & i_pwrite & addr_hit;

	// control write effects
	assign ctrl_wr   = wr_fire & hit_ctrl & i_pstrb[0];
	assign en_wr_val = i_pwdata[`TFG_CTRL_EN_BIT];
	assign start     = ctrl_wr & en_wr_val & ~test_generate_enable_q;
	assign ins_cmd   = ctrl_wr & i_pwdata[`TFG_CTRL_INS_BIT] & (test_generate_enable_q | en_wr_val);

	// read selection
	assign rd_mux = hit_ctrl   ? {31'h0000_0000, test_generate_enable_q} :
	                hit_len    ? {16'h0000, frame_len_q} :
	                hit_status ? {29'h0000_0000, gen_busy, test_generate_enable_q, sync_q} :
	                hit_frx    ? frames_received_count_q :
	                hit_efc    ? errored_frame_count_q :
	                hit_esc    ? errored_second_count_q :
	                hit_test_elapsed_seconds   ? test_elapsed_seconds_q :
	                hit_iec    ? inserted_error_count_q :
	                32'h0000_0000;

	// read capture and access tracking
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			prdata_q <= 32'h0000_0000;
			acc_q    <= 1'b0;
		end else if (i_ce) begin
			if (i_psel) begin
				prdata_q <= rd_mux;
			end
			acc_q <= i_psel & ~(i_penable & o_pready);
		end
	end

	// enable and frame length
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			test_generate_enable_q <= 1'b0;
			frame_len_q            <= `TFG_LEN_RST;
		end else if (i_ce) begin
			if (ctrl_wr) begin
				test_generate_enable_q <= en_wr_val;
			end
			if (wr_fire && hit_len) begin
				if (i_pstrb[0]) frame_len_q[7:0] <= i_pwdata[7:0];
				if (i_pstrb[1]) frame_len_q[15:8] <= i_pwdata[15:8];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// one-second time base

	logic sec_tick;

	tfg_sec_tick #(
		.P_CYCLES (P_SEC_CYCLES)
	) u_sec (
		.i_ref_clk (i_ref_clk),
		.i_nrst    (i_nrst),
		.i_ce      (i_ce),
		.i_restart (start),
		.o_tick    (sec_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// frame generator

	tfg_gen_st_t gen_st_q;
	tfg_gen_st_t gen_st_d;
	logic [15:0] gen_idx_q;
	logic [15:0] gen_idx_d;
	logic        gen_push;
	logic        buf_ready;
	logic        gen_last;
	logic        inject;
	logic [7:0]  gen_byte;

	// byte k of a frame carries k, corrupted once per pending insert
	assign gen_last = ({16'h0000, gen_idx_q} + 32'h0000_0001) >= {16'h0000, frame_len_q};
	assign gen_push = (gen_st_q == GEN_SEND) & buf_ready & i_ce;
	assign inject   = gen_push & ins_pend_q;
	assign gen_byte = gen_idx_q[7:0] ^ {7'h00, inject};
	assign gen_busy = (gen_st_q == GEN_SEND);

	// next state: a running frame is finished before stopping
	always_comb begin
		gen_st_d  = gen_st_q;
		gen_idx_d = gen_idx_q;
		case (gen_st_q)
			GEN_IDLE: begin
				gen_idx_d = 16'h0000;
				if (test_generate_enable_q) begin
					gen_st_d = GEN_SEND;
				end
			end
			GEN_SEND: begin
				if (gen_push) begin
					if (gen_last) begin
						gen_idx_d = 16'h0000;
						if (!test_generate_enable_q) begin
							gen_st_d = GEN_IDLE;
						end
					end else begin
						gen_idx_d = gen_idx_q + 16'h0001;
					end
				end
			end
			default: begin
				gen_st_d  = GEN_IDLE;
				gen_idx_d = 16'h0000;
			end
		endcase
	end

	// generator registers
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			gen_st_q  <= GEN_IDLE;
			gen_idx_q <= 16'h0000;
		end else if (i_ce) begin
			gen_st_q  <= gen_st_d;
			gen_idx_q <= gen_idx_d;
		end
	end

	// pending insert: a new command wins over consumption
	assign ins_pend_d = (ins_pend_q & ~inject & ~start) | ins_cmd;

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ins_pend_q <= 1'b0;
		end else if (i_ce) begin
			ins_pend_q <= ins_pend_d;
		end
	end

	// buffer toward the line absorbs receiver stalls
	logic [8:0] buf_out;

	tfg_buf2 #(
		.P_WIDTH (9)
	) u_txbuf (
		.i_ref_clk (i_ref_clk),
		.i_nrst    (i_nrst),
		.i_ce      (i_ce),
		.i_valid   (gen_st_q == GEN_SEND),
		.o_ready   (buf_ready),
		.i_data    ({gen_last, gen_byte}),
		.o_valid   (o_tx_valid),
		.i_ready   (i_tx_ready),
		.o_data    (buf_out)
	);

	assign o_tx_data = buf_out[7:0];
	assign o_tx_last = buf_out[8];

	////////////////////////////////////////////////////////////////////////
	// frame checker

	logic [15:0] rx_idx_q;
	logic        rx_bad_q;
	logic        rx_take;
	logic        byte_bad;
	logic        frame_end;
	logic        frame_bad;
	logic        len_bad;
	logic        frame_good;

	// each byte must carry its position, length must match
	assign rx_take    = i_rx_valid & i_ce;
	assign byte_bad   = (i_rx_data != rx_idx_q[7:0]) | i_rx_err;
	assign len_bad    = ({16'h0000, rx_idx_q} + 32'h0000_0001) != {16'h0000, frame_len_q};
	assign frame_end  = rx_take & i_rx_last;
	assign frame_bad  = frame_end & (rx_bad_q | byte_bad | len_bad);
	assign frame_good = frame_end & ~(rx_bad_q | byte_bad | len_bad);

	// position and error accumulation within a frame
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rx_idx_q <= 16'h0000;
			rx_bad_q <= 1'b0;
		end else if (i_ce) begin
			if (frame_end) begin
				rx_idx_q <= 16'h0000;
				rx_bad_q <= 1'b0;
			end else if (rx_take) begin
				rx_idx_q <= rx_idx_q + 16'h0001;
				rx_bad_q <= rx_bad_q | byte_bad;
			end
		end
	end

	// lock after a run of good frames, drop after a run of bad ones
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sync_q     <= 1'b0;
			good_run_q <= 2'h0;
			bad_run_q  <= 2'h0;
		end else if (i_ce) begin
			if (start) begin
				sync_q     <= 1'b0;
				good_run_q <= 2'h0;
				bad_run_q  <= 2'h0;
			end else if (test_generate_enable_q && frame_good) begin
				bad_run_q <= 2'h0;
				if (good_run_q != `TFG_SYNC_SET) good_run_q <= good_run_q + 2'h1;
				if (good_run_q + 2'h1 >= `TFG_SYNC_SET) sync_q <= 1'b1;
			end else if (test_generate_enable_q && frame_bad) begin
				good_run_q <= 2'h0;
				if (bad_run_q != `TFG_SYNC_LOSS) bad_run_q <= bad_run_q + 2'h1;
				if (bad_run_q + 2'h1 >= `TFG_SYNC_LOSS) sync_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// test counters

	logic run_err;

	// any error marks the current second; the tick counts it and closes the second
	assign run_err   = test_generate_enable_q & (frame_bad | inject);
	assign sec_err_d = (start | sec_tick) ? 1'b0 : (sec_err_q | run_err);

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sec_err_q <= 1'b0;
		end else if (i_ce) begin
			sec_err_q <= sec_err_d;
		end
	end

	// counters clear at test start and advance only while running
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			frames_received_count_q <= 32'h0000_0000;
			errored_frame_count_q   <= 32'h0000_0000;
			errored_second_count_q  <= 32'h0000_0000;
			test_elapsed_seconds_q  <= 32'h0000_0000;
			inserted_error_count_q  <= 32'h0000_0000;
		end else if (i_ce) begin
			if (start) begin
				frames_received_count_q <= 32'h0000_0000;
				errored_frame_count_q   <= 32'h0000_0000;
				errored_second_count_q  <= 32'h0000_0000;
				test_elapsed_seconds_q  <= 32'h0000_0000;
				inserted_error_count_q  <= 32'h0000_0000;
			end else if (test_generate_enable_q) begin
				frames_received_count_q <= tfg_cnt_inc(frames_received_count_q, frame_end);
				errored_frame_count_q   <= tfg_cnt_inc(errored_frame_count_q, frame_bad);
				errored_second_count_q  <= tfg_cnt_inc(errored_second_count_q,
				                                       sec_tick & (sec_err_q | run_err));
				test_elapsed_seconds_q  <= tfg_cnt_inc(test_elapsed_seconds_q, sec_tick);
				inserted_error_count_q  <= tfg_cnt_inc(inserted_error_count_q, inject);
			end
		end
	end

endmodule

//--- testbench/tfg_top_sva.sv
`timescale 1ns/10ps
`include "tfg_defines.svh"
module tfg_top_sva #(
	parameter int unsigned P_SEC_CYCLES = 100
) (
	// clock, reset, enable
	input wire logic		i_ref_clk,
	input wire logic		i_nrst,
	input wire logic		i_ce,
	// apb
	input wire logic		i_psel,
	input wire logic		i_penable,
	input wire logic		i_pwrite,
	input wire logic [11:0]	i_paddr,
	input wire logic [31:0]	i_pwdata,
	input wire logic [3:0]	i_pstrb,
	input wire logic [31:0]	o_prdata,
	input wire logic		o_pready,
	input wire logic		o_pslverr,
	// byte streams
	input wire logic		o_tx_valid,
	input wire logic		i_tx_ready,
	input wire logic [7:0]	o_tx_data,
	input wire logic		o_tx_last,
	input wire logic		i_rx_valid,
	input wire logic [7:0]	i_rx_data,
	input wire logic		i_rx_last,
	input wire logic		i_rx_err
);
	logic			acc_w;
	logic			take_w;
	logic			ctl_w;
	logic [15:0]	last_w;
	logic			en_q;
	logic [15:0]	len_q;
	logic [15:0]	pos_q;
	logic [3:0]		idle_q;
	logic			ins_q;

	// completed access, accepted byte, control write, last byte position
	assign acc_w  = i_psel & i_penable & o_pready;
	assign take_w = o_tx_valid & i_tx_ready & i_ce;
	assign ctl_w  = acc_w & i_pwrite & (i_paddr == `TFG_ADDR_CTRL) & i_pstrb[0];
	assign last_w = (len_q < 16'h0002) ? 16'h0000 : len_q - 16'h0001;

	// shadow of enable, length, frame position and idle time
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			en_q   <= 1'b0;
			len_q  <= `TFG_LEN_RST;
			pos_q  <= 16'h0000;
			idle_q <= 4'h0;
			ins_q  <= 1'b0;
		end else begin
			if (ctl_w)
				en_q <= i_pwdata[0];
			if (acc_w && i_pwrite && i_paddr == `TFG_ADDR_LEN && i_pstrb[1:0] == 2'h3)
				len_q <= i_pwdata[15:0];
			if (take_w)
				pos_q <= o_tx_last ? 16'h0000 : pos_q + 16'h0001;
			if (o_tx_valid)
				idle_q <= 4'h0;
			else if (i_ce && idle_q != 4'hF)
				idle_q <= idle_q + 4'h1;
			// insert outstanding until a byte with a flipped low bit leaves
			if (ctl_w && i_pwdata[0] && !en_q)
				ins_q <= i_pwdata[1];
			else if (ctl_w && i_pwdata[1] && en_q)
				ins_q <= 1'b1;
			else if (take_w && o_tx_data[0] != pos_q[0])
				ins_q <= 1'b0;
		end
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	AST_PREADY_NOWAIT: assert property ((i_psel && !i_penable && i_ce) ##1 (i_penable && i_ce) |-> o_pready)
		else $error("pready missing in first access cycle");
	AST_PREADY_FROZEN: assert property (!i_ce |-> !o_pready)
		else $error("pready while clock enable low");
	AST_SLVERR_DECODE: assert property (acc_w && i_paddr[1:0] == 2'h0 |-> o_pslverr == (i_paddr > 12'h01C))
		else $error("pslverr does not match address decode");
	AST_UNMAPPED_ZERO: assert property (acc_w && o_pslverr && !i_pwrite |-> o_prdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	AST_RESET_QUIET: assert property ($rose(i_nrst) |-> !o_tx_valid && !o_pready && !o_pslverr)
		else $error("outputs active after reset release");
	AST_TX_HOLD: assert property (o_tx_valid && !take_w |=> o_tx_valid && $stable(o_tx_data) && $stable(o_tx_last))
		else $error("tx byte changed before taken");
	AST_TX_POSITION: assert property (take_w |-> o_tx_data[7:1] == pos_q[7:1])
		else $error("tx byte value not its position");
	AST_TX_FRAME_LEN: assert property (take_w |-> o_tx_last == (pos_q == last_w))
		else $error("tx frame length wrong");
	AST_TX_START: assert property (ctl_w && i_pwdata[0] && !i_pwdata[1] && !en_q && idle_q == 4'hF
		|-> ##[1:3] (o_tx_valid && o_tx_data == 8'h00))
		else $error("test did not start");
	AST_TX_STOPPED: assert property (!en_q && idle_q == 4'hF |=> !o_tx_valid)
		else $error("tx active while test off");
	AST_TX_FLIP_ONCE: assert property (take_w && o_tx_data[0] != pos_q[0] |-> ins_q)
		else $error("tx low bit flipped without insert command");
endmodule

bind tfg_top tfg_top_sva #(.P_SEC_CYCLES(P_SEC_CYCLES)) sva_u (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
	.i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready), .o_tx_data(o_tx_data), .o_tx_last(o_tx_last),
	.i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .i_rx_last(i_rx_last), .i_rx_err(i_rx_err));

//--- testbench/tfg_loop_model.sv
`timescale 1ns/10ps
module tfg_loop_model (
	// clock, reset, enable, stall control
	input wire logic		i_ref_clk,
	input wire logic		i_nrst,
	input wire logic		i_ce,
	input wire logic		i_hold,
	// stream from the block
	input wire logic		i_tx_valid,
	input wire logic [7:0]	i_tx_data,
	input wire logic		i_tx_last,
	output logic			o_tx_ready,
	// stream back into the block
	output logic			o_rx_valid,
	output logic [7:0]		o_rx_data,
	output logic			o_rx_last,
	output logic			o_rx_err,
	output logic [31:0]		o_frames
);
	logic stall_q;

	// random stalls, none accepted while held
	assign o_tx_ready = !i_hold && !stall_q;
	assign o_rx_err   = 1'b0;

	// echo each accepted byte one cycle later; idle lines toggle
	always @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			stall_q    <= 1'b0;
			o_rx_valid <= 1'b0;
			o_rx_data  <= 8'h00;
			o_rx_last  <= 1'b0;
			o_frames   <= 32'h0;
		end else if (i_ce) begin
			stall_q <= ($urandom % 3) == 0;
			if (i_tx_valid && o_tx_ready) begin
				o_rx_valid <= 1'b1;
				o_rx_data  <= i_tx_data;
				o_rx_last  <= i_tx_last;
				o_frames   <= o_frames + {31'h0, i_tx_last};
			end else begin
				o_rx_valid <= 1'b0;
				o_rx_data  <= ~o_rx_data;
				o_rx_last  <= ~o_rx_last;
			end
		end
	end
endmodule

//--- testbench/hdlc_test_frame_gen_check_tb_top.sv
`timescale 1ns/10ps
`include "tfg_defines.svh"
module hdlc_test_frame_gen_check_tb_top
	import tfg_pkg::*;
	;
	typedef struct {
		tfg_cnt_t	val;
		tfg_cnt_t	mask;
		logic		se;
	} tfg_exp_t;
	localparam int SEC = 400;
	logic			clk, nrst, ce, hold, psel, penable, pwrite;
	logic [11:0]	paddr;
	logic [31:0]	pwdata, prdata, frames;
	logic [3:0]		pstrb;
	logic			pready, pslverr, tx_valid, tx_ready, tx_last, rx_valid, rx_last, rx_err;
	logic [7:0]		tx_data, rx_data;
	tfg_exp_t		q[$];
	tfg_exp_t		ex;
	int				err_total = 0;
	int				cmp_count = 0;

	tfg_top #(.P_SEC_CYCLES(SEC)) dut_u (.i_ref_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_tx_valid(tx_valid),
		.i_tx_ready(tx_ready), .o_tx_data(tx_data), .o_tx_last(tx_last), .i_rx_valid(rx_valid),
		.i_rx_data(rx_data), .i_rx_last(rx_last), .i_rx_err(rx_err));
	tfg_loop_model far_u (.i_ref_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_hold(hold), .i_tx_valid(tx_valid),
		.i_tx_data(tx_data), .i_tx_last(tx_last), .o_tx_ready(tx_ready), .o_rx_valid(rx_valid),
		.o_rx_data(rx_data), .o_rx_last(rx_last), .o_rx_err(rx_err), .o_frames(frames));

	// clock
	always #5 clk = ~clk;

	task automatic cmp(input string name, input tfg_cnt_t exp, input tfg_cnt_t got);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic cmp_bit(input string name, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic stop_test();
		if (err_total == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// one apb transfer, optionally frozen one access cycle; note goes on the queue first
	task automatic apb(input logic w, input logic [11:0] a, input tfg_cnt_t d, input tfg_exp_t e,
		input logic st, output tfg_cnt_t r);
		q.push_back(e);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		ce      <= !st;
		if (st) begin
			@(posedge clk);
			ce <= 1'b1;
		end
		// hold the request until the edge that samples pready high
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		r = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [11:0] a, input tfg_cnt_t e, input tfg_cnt_t m, input logic se,
		output tfg_cnt_t r);
		apb(1'b0, a, 32'h0, '{e, m, se}, 1'b0, r);
	endtask

	task automatic wr(input logic [11:0] a, input tfg_cnt_t d, input logic se);
		tfg_cnt_t r;
		apb(1'b1, a, d, '{32'h0, 32'h0, se}, 1'b0, r);
	endtask

	// result watcher: oldest note against each completed access
	always @(posedge clk) begin
		if (psel && penable && pready) begin
			ex = q.pop_front();
			if (ex.mask !== 32'h0)
				cmp("prdata", ex.val & ex.mask, prdata & ex.mask);
			cmp_bit("pslverr", ex.se, pslverr);
		end
	end

	initial begin
		tfg_cnt_t		v;
		tfg_cnt_t		w;
		tfg_cnt_t		base;
		logic [15:0]	len;
		void'($urandom(32'hFBE3C0C0));
		clk     = 1'b0;
		nrst    = 1'b0;
		ce      = 1'b1;
		hold    = 1'b1;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h0;
		pstrb   = 4'hF;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		// defaults after reset, one read stretched by a frozen cycle
		for (int a = 0; a < 32; a += 4)
			apb(1'b0, a[11:0], 32'h0, '{(a == 4) ? {16'h0, `TFG_LEN_RST} : 32'h0, '1, 1'b0}, a == 8, v);
		// unmapped place and read-only counter
		rd(12'h020, 32'h0, '1, 1'b1, v);
		wr(12'h020, 32'h1, 1'b1);
		wr(`TFG_ADDR_FRX, 32'h5, 1'b0);
		rd(`TFG_ADDR_FRX, 32'h0, '1, 1'b0, v);
		// random length, run looped back until locked
		len = 16'h2 + 16'($urandom % 8);
		wr(`TFG_ADDR_LEN, {16'h0, len}, 1'b0);
		rd(`TFG_ADDR_LEN, {16'h0, len}, '1, 1'b0, v);
		base = frames;
		hold <= 1'b0;
		wr(`TFG_ADDR_CTRL, 32'h1, 1'b0);
		repeat (300) @(posedge clk);
		hold <= 1'b1;
		repeat (10) @(posedge clk);
		rd(`TFG_ADDR_STATUS, 32'h3, 32'h3, 1'b0, v);
		rd(`TFG_ADDR_FRX, frames - base, '1, 1'b0, v);
		// two inserted errors early in one second
		hold <= 1'b0;
		rd(`TFG_ADDR_TEST_ELAPSED_SECONDS, 32'h0, 32'h0, 1'b0, v);
		w = v;
		for (int i = 0; i < 300 && w === v; i++)
			rd(`TFG_ADDR_TEST_ELAPSED_SECONDS, 32'h0, 32'h0, 1'b0, w);
		cmp("test_elapsed_seconds_step", v + 32'h0000_0001, w);
		wr(`TFG_ADDR_CTRL, 32'h3, 1'b0);
		repeat (60) @(posedge clk);
		wr(`TFG_ADDR_CTRL, 32'h3, 1'b0);
		repeat (60) @(posedge clk);
		hold <= 1'b1;
		repeat (10) @(posedge clk);
		rd(`TFG_ADDR_IEC, 32'h2, '1, 1'b0, v);
		rd(`TFG_ADDR_EFC, 32'h2, '1, 1'b0, v);
		rd(`TFG_ADDR_FRX, frames - base, '1, 1'b0, v);
		rd(`TFG_ADDR_STATUS, 32'h1, 32'h1, 1'b0, v);
		repeat (SEC) @(posedge clk);
		rd(`TFG_ADDR_ESC, 32'h1, '1, 1'b0, v);
		// four seconds between two reads
		rd(`TFG_ADDR_TEST_ELAPSED_SECONDS, 32'h0, 32'h0, 1'b0, v);
		repeat (4 * SEC - 3) @(posedge clk);
		rd(`TFG_ADDR_TEST_ELAPSED_SECONDS, v + 32'h4, '1, 1'b0, w);
		// stop: frame in progress finishes, counts freeze
		hold <= 1'b0;
		wr(`TFG_ADDR_CTRL, 32'h0, 1'b0);
		repeat (100) @(posedge clk);
		rd(`TFG_ADDR_STATUS, 32'h0, 32'h6, 1'b0, v);
		rd(`TFG_ADDR_TEST_ELAPSED_SECONDS, 32'h0, 32'h0, 1'b0, v);
		repeat (SEC + 10) @(posedge clk);
		rd(`TFG_ADDR_TEST_ELAPSED_SECONDS, v, '1, 1'b0, w);
		// restart with a new length clears every count and sync
		hold <= 1'b1;
		base = frames;
		len = 16'h2 + 16'($urandom % 8);
		wr(`TFG_ADDR_LEN, {16'h0, len}, 1'b0);
		wr(`TFG_ADDR_CTRL, 32'h1, 1'b0);
		for (int a = 12; a < 32; a += 4)
			rd(a[11:0], 32'h0, '1, 1'b0, v);
		rd(`TFG_ADDR_STATUS, 32'h0, 32'h1, 1'b0, v);
		hold <= 1'b0;
		repeat (200) @(posedge clk);
		hold <= 1'b1;
		repeat (10) @(posedge clk);
		rd(`TFG_ADDR_FRX, frames - base, '1, 1'b0, v);
		stop_test();
	end

	// watchdog
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		stop_test();
	end
endmodule
